/* File: hw/fpg_gpio.sv */
/*
 * four port gpio block: two-bit port a, eight-bit ports b, c and d,
 * with direction, output level, pull-up, open-drain and high-sink
 * settings in special-function registers, plus peripheral takeover.
 * level reads follow the gpio direction bits, not a peripheral's
 * direction, so a peripheral-owned pin whose gpio direction bit is 0 reads its stored level.
 * assumes the core's sfr port is on clk_sys_in, one strobe per cycle;
 * the pad resolves drive from pin_out/pin_oe and adds the pull-up;
 * peripheral controls and the two-wire enable are on the same clock.
 * pin vectors: a [1:0], b [9:2], c [17:10], d [25:18].
 */
`timescale 1ns/1ns
module fpg_gpio
   import fpg_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_n_in,
   input  wire logic [7:0]           sfr_addr_in,
   input  wire logic                 sfr_wr_in,
   input  wire logic [7:0]           sfr_wdata_in,
   input  wire logic                 sfr_rd_in,
   output logic      [7:0]           sfr_rdata_out,
   input  wire logic [FPG_PIN_W-1:0] pin_in,
   output logic      [FPG_PIN_W-1:0] pin_out,
   output logic      [FPG_PIN_W-1:0] pin_oe_out,
   output logic      [FPG_PIN_W-1:0] pin_pullup_out,
   output logic      [7:0]           common_drive_mode_out,
   input  wire logic [FPG_PIN_W-1:0] periph_sel_in,
   input  wire logic [FPG_PIN_W-1:0] periph_out_in,
   input  wire logic [FPG_PIN_W-1:0] periph_oe_in,
   input  wire logic                 iic_en_in
);
   typedef struct packed {
      logic [1:0]           lvl_a;
      logic [7:0]           lvl_b;
      logic [7:0]           lvl_c;
      logic [7:0]           lvl_d;
      logic [1:0]           dir_a;
      logic [7:0]           dir_b;
      logic [7:0]           dir_c;
      logic [7:0]           dir_d;
      logic [1:0]           pu_a;
      logic [7:0]           pu_b;
      logic [7:0]           pu_c;
      logic [7:0]           pu_d;
      logic [7:0]           hsink;
      logic [1:0]           od;
      logic [7:0]           rdata;
      logic [FPG_PIN_W-1:0] oe;
      logic [FPG_PIN_W-1:0] out;
   } fpg_state_t;

   // registered state and its next value
   fpg_state_t           st;
   fpg_state_t           next_st;

   // synchronised pad levels
   logic [FPG_PIN_W-1:0] pin_sync;

   // flat per-pin views, peripheral merge and pad drive
   logic [FPG_PIN_W-1:0] lvl_all;
   logic [FPG_PIN_W-1:0] dir_all;
   logic [FPG_PIN_W-1:0] od_all;
   logic [FPG_PIN_W-1:0] eff_lvl;
   logic [FPG_PIN_W-1:0] eff_dir;
   logic [FPG_PIN_W-1:0] readback;
   logic [FPG_PIN_W-1:0] drive_oe;
   logic [FPG_PIN_W-1:0] drive_lvl;

   // pin levels cross into the clock domain here
   fpg_sync u_sync (
      .clk_sys_in   (clk_sys_in),
      .rst_n_in     (rst_n_in),
      .pin_in       (pin_in),
      .pin_sync_out (pin_sync)
   );

   // merge a 1-for-input mask with sample and stored level
   function automatic logic [FPG_PIN_W-1:0] merge_by_dir(
      input logic [FPG_PIN_W-1:0] dir,
      input logic [FPG_PIN_W-1:0] when_in,
      input logic [FPG_PIN_W-1:0] when_out
   );
      merge_by_dir = (dir & when_in) | (~dir & when_out);
   endfunction : merge_by_dir

   // widen a port a byte to eight bits with zeros above bit 1
   function automatic logic [7:0] pad_a(input logic [1:0] v);
      pad_a = {6'h00, v};
   endfunction : pad_a

   // pick one eight-bit port out of a flat pin vector
   function automatic logic [7:0] port_byte(
      input logic [FPG_PIN_W-1:0] v,
      input int                   lsb
   );
      port_byte = v[lsb +: 8];
   endfunction : port_byte

   // flat views of the per-port registers
   always_comb begin
      lvl_all = {st.lvl_d, st.lvl_c, st.lvl_b, st.lvl_a};
      dir_all = {st.dir_d, st.dir_c, st.dir_b, st.dir_a};
      // the two-wire slave needs both port a pins open drain
      od_all  = {24'h000000, st.od | {2{iic_en_in}}};
   end

   // peripheral ownership takes level and direction
   always_comb begin
      eff_lvl = (periph_sel_in & periph_out_in)
              | (~periph_sel_in & lvl_all);
      eff_dir = (periph_sel_in & ~periph_oe_in)
              | (~periph_sel_in & dir_all);
   end

   // level readback: synchronised pad for inputs, stored level else
   always_comb begin
      readback = merge_by_dir(dir_all, pin_sync, lvl_all);
   end

   // pad drive: output pins only; open drain never drives high,
   // so a bus partner can pull the line low without contention
   always_comb begin
      drive_oe  = ~eff_dir & (~od_all | ~eff_lvl);
      drive_lvl = eff_lvl & ~od_all;
   end

   // register writes, read capture and pin drive
   always_comb begin
      next_st = st;
      if (sfr_wr_in) begin
         case (sfr_addr_in)
            FPG_PORT_A_LEVEL:      next_st.lvl_a = sfr_wdata_in[1:0];
            FPG_PORT_B_LEVEL:      next_st.lvl_b = sfr_wdata_in;
            FPG_PORT_C_LEVEL:      next_st.lvl_c = sfr_wdata_in;
            FPG_PORT_D_LEVEL:      next_st.lvl_d = sfr_wdata_in;
            FPG_PORT_A_PULLUP:     next_st.pu_a  = sfr_wdata_in[1:0];
            FPG_PORT_B_PULLUP:     next_st.pu_b  = sfr_wdata_in;
            FPG_PORT_C_PULLUP:     next_st.pu_c  = sfr_wdata_in;
            FPG_PORT_D_PULLUP:     next_st.pu_d  = sfr_wdata_in;
            FPG_PORT_A_DIRECTION:  next_st.dir_a = sfr_wdata_in[1:0];
            FPG_PORT_B_DIRECTION:  next_st.dir_b = sfr_wdata_in;
            FPG_PORT_C_DIRECTION:  next_st.dir_c = sfr_wdata_in;
            FPG_PORT_D_DIRECTION:  next_st.dir_d = sfr_wdata_in;
            FPG_HIGH_SINK_SELECT:  next_st.hsink = sfr_wdata_in;
            FPG_OPEN_DRAIN_SELECT: next_st.od    = sfr_wdata_in[1:0];
            default: ;
         endcase
      end
      // read data captured on the strobe, held until the next read
      if (sfr_rd_in) begin
         case (sfr_addr_in)
            FPG_PORT_A_LEVEL:
               next_st.rdata = pad_a(readback[FPG_A_LSB +: 2]);
            FPG_PORT_B_LEVEL:
               next_st.rdata = port_byte(readback, FPG_B_LSB);
            FPG_PORT_C_LEVEL:
               next_st.rdata = port_byte(readback, FPG_C_LSB);
            FPG_PORT_D_LEVEL:
               next_st.rdata = port_byte(readback, FPG_D_LSB);
            FPG_PORT_A_PULLUP:     next_st.rdata = pad_a(st.pu_a);
            FPG_PORT_B_PULLUP:     next_st.rdata = st.pu_b;
            FPG_PORT_C_PULLUP:     next_st.rdata = st.pu_c;
            FPG_PORT_D_PULLUP:     next_st.rdata = st.pu_d;
            FPG_PORT_A_DIRECTION:  next_st.rdata = pad_a(st.dir_a);
            FPG_PORT_B_DIRECTION:  next_st.rdata = st.dir_b;
            FPG_PORT_C_DIRECTION:  next_st.rdata = st.dir_c;
            FPG_PORT_D_DIRECTION:  next_st.rdata = st.dir_d;
            FPG_HIGH_SINK_SELECT:  next_st.rdata = st.hsink;
            FPG_OPEN_DRAIN_SELECT: next_st.rdata = pad_a(st.od);
            default:               next_st.rdata = FPG_UNMAPPED_RD;
         endcase
      end
      // pad drive registered so every pin output comes from a flop
      next_st.oe  = drive_oe;
      next_st.out = drive_lvl;
   end

   // state register
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st.lvl_a <= FPG_A_LEVEL_RST;
         st.lvl_b <= FPG_LEVEL_RST;
         st.lvl_c <= FPG_LEVEL_RST;
         st.lvl_d <= FPG_LEVEL_RST;
         st.dir_a <= FPG_A_DIR_RST;
         st.dir_b <= FPG_DIR_RST;
         st.dir_c <= FPG_DIR_RST;
         st.dir_d <= FPG_DIR_RST;
         st.pu_a  <= FPG_A_PU_RST;
         st.pu_b  <= FPG_PU_RST;
         st.pu_c  <= FPG_PU_RST;
         st.pu_d  <= FPG_PU_RST;
         st.hsink <= FPG_HSINK_RST;
         st.od    <= FPG_OD_RST;
         st.rdata <= FPG_RDATA_RST;
         st.oe    <= FPG_PIN_OE_RST;
         st.out   <= FPG_PIN_OUT_RST;
      end else begin
         st <= next_st;
      end
   end

   // read data straight from its register, held until the next read
   assign sfr_rdata_out         = st.rdata;

   // pad drive straight from the state register
   assign pin_out               = st.out;
   assign pin_oe_out            = st.oe;

   // pull-ups follow their bits whatever the pin direction
   assign pin_pullup_out        = {st.pu_d, st.pu_c, st.pu_b, st.pu_a};
   assign common_drive_mode_out = st.hsink;
endmodule : fpg_gpio

/* File: hw/fpg_pkg.sv */
/*
 * constants for the four port gpio block: register offsets on the
 * special-function register port, reset values and pin lane layout.
 * assumes a single 125 MHz system clock domain.
 */
package fpg_pkg;
   // special-function register offsets
   localparam logic [7:0] FPG_PORT_A_LEVEL      = 8'hF8;
   localparam logic [7:0] FPG_PORT_B_LEVEL      = 8'h80;
   localparam logic [7:0] FPG_PORT_C_LEVEL      = 8'h90;
   localparam logic [7:0] FPG_PORT_D_LEVEL      = 8'h98;
   localparam logic [7:0] FPG_PORT_A_PULLUP     = 8'hDD;
   localparam logic [7:0] FPG_PORT_B_PULLUP     = 8'hDE;
   localparam logic [7:0] FPG_PORT_C_PULLUP     = 8'hDF;
   localparam logic [7:0] FPG_PORT_D_PULLUP     = 8'hE2;
   localparam logic [7:0] FPG_PORT_A_DIRECTION  = 8'hEA;
   localparam logic [7:0] FPG_PORT_B_DIRECTION  = 8'hEB;
   localparam logic [7:0] FPG_PORT_C_DIRECTION  = 8'hEC;
   localparam logic [7:0] FPG_PORT_D_DIRECTION  = 8'hED;
   localparam logic [7:0] FPG_HIGH_SINK_SELECT  = 8'hEE;
   localparam logic [7:0] FPG_OPEN_DRAIN_SELECT = 8'hEF;

   // pin vector layout: a in [1:0], b [9:2], c [17:10], d [25:18]
   localparam int FPG_PIN_W  = 26;
   localparam int FPG_A_LSB  = 0;
   localparam int FPG_B_LSB  = 2;
   localparam int FPG_C_LSB  = 10;
   localparam int FPG_D_LSB  = 18;

   // reset values
   localparam logic [1:0] FPG_A_LEVEL_RST = 2'h3;
   localparam logic [7:0] FPG_LEVEL_RST   = 8'hFF;
   localparam logic [1:0] FPG_A_DIR_RST   = 2'h3;
   localparam logic [7:0] FPG_DIR_RST     = 8'hFF;
   localparam logic [1:0] FPG_A_PU_RST    = 2'h0;
   localparam logic [7:0] FPG_PU_RST      = 8'h00;
   localparam logic [7:0] FPG_HSINK_RST   = 8'h00;
   localparam logic [1:0] FPG_OD_RST      = 2'h0;
   localparam logic [7:0] FPG_RDATA_RST   = 8'h00;
   localparam logic [7:0] FPG_UNMAPPED_RD = 8'h00;
   localparam logic [FPG_PIN_W-1:0] FPG_PIN_OE_RST  = 26'h0000000;
   localparam logic [FPG_PIN_W-1:0] FPG_PIN_OUT_RST = 26'h3FFFFFF;
   localparam logic [FPG_PIN_W-1:0] FPG_SYNC_RST    = 26'h3FFFFFF;
endpackage : fpg_pkg

/* File: hw/fpg_sync.sv */
/*
 * two flip-flop synchroniser for all gpio pin levels.
 * assumes pins are asynchronous to clk_sys_in.
 */
`timescale 1ns/1ns
module fpg_sync
   import fpg_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_n_in,
   input  wire logic [FPG_PIN_W-1:0] pin_in,
   output logic      [FPG_PIN_W-1:0] pin_sync_out
);
   typedef struct packed {
      logic [FPG_PIN_W-1:0] first;
      logic [FPG_PIN_W-1:0] second;
   } fpg_sync_t;

   fpg_sync_t st;
   fpg_sync_t next_st;

   // first stage feeds only the second stage
   always_comb begin
      next_st        = st;
      next_st.first  = pin_in;
      next_st.second = st.first;
   end

   // state register
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st.first  <= FPG_SYNC_RST;
         st.second <= FPG_SYNC_RST;
      end else begin
         st <= next_st;
      end
   end

   assign pin_sync_out = st.second;
endmodule : fpg_sync

/* File: tb/fpg_gpio_properties.sv */
/* timing checks on the fpg_gpio ports.
   assumes a bind to fpg_gpio and its one clock. */
`timescale 1ns/1ns
module fpg_gpio_properties
   import fpg_pkg::*;
(
   input wire logic                 clk_sys_in,
   input wire logic                 rst_n_in,
   input wire logic [7:0]           sfr_addr_in,
   input wire logic                 sfr_wr_in,
   input wire logic [7:0]           sfr_wdata_in,
   input wire logic                 sfr_rd_in,
   input wire logic [7:0]           sfr_rdata_out,
   input wire logic [FPG_PIN_W-1:0] pin_out,
   input wire logic [FPG_PIN_W-1:0] pin_oe_out,
   input wire logic [FPG_PIN_W-1:0] pin_pullup_out,
   input wire logic [7:0]           common_drive_mode_out,
   input wire logic [FPG_PIN_W-1:0] periph_sel_in,
   input wire logic [FPG_PIN_W-1:0] periph_out_in,
   input wire logic [FPG_PIN_W-1:0] periph_oe_in,
   input wire logic                 iic_en_in
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // one write to an address, then a quiet write strobe
   sequence wr_idle(logic [7:0] a);
      sfr_wr_in && sfr_addr_in == a ##1 !sfr_wr_in;
   endsequence
   unmapped_read_a:
   assert property (sfr_rd_in && sfr_addr_in == 8'h00
      |=> sfr_rdata_out == 8'h00) else $error("unmapped read not 0");
   port_a_bits_a:
   assert property (sfr_rd_in && sfr_addr_in inside {8'hF8, 8'hEA, 8'hDD,
      8'hEF} |=> sfr_rdata_out[7:2] == 6'h00) else $error("a bits set");
   dir_b_drive_a:
   assert property (wr_idle(FPG_PORT_B_DIRECTION) ##0 !periph_sel_in[9:2]
      |=> pin_oe_out[9:2] == ~$past(sfr_wdata_in, 2))
      else $error("b enable wrong");
   level_c_drive_a:
   assert property (wr_idle(FPG_PORT_C_LEVEL) ##0 !periph_sel_in[17:10]
      |=> (pin_out[17:10] & pin_oe_out[17:10])
      == ($past(sfr_wdata_in, 2) & pin_oe_out[17:10]))
      else $error("c level");
   iic_open_drain_a:
   assert property (iic_en_in ##1 iic_en_in
      |-> (pin_oe_out[1:0] & pin_out[1:0]) == 2'h0) else $error("a high");
   periph_take_a:
   assert property (periph_sel_in[9:2] == 8'hFF
      |=> pin_out[9:2] == $past(periph_out_in[9:2])
      && pin_oe_out[9:2] == $past(periph_oe_in[9:2])) else $error("periph");
   pullup_b_a:
   assert property (wr_idle(FPG_PORT_B_PULLUP) ##1 !sfr_wr_in
      |=> pin_pullup_out[9:2] == $past(sfr_wdata_in, 3))
      else $error("pull-up wrong");
   high_sink_a:
   assert property (wr_idle(FPG_HIGH_SINK_SELECT) ##1 !sfr_wr_in
      |=> common_drive_mode_out == $past(sfr_wdata_in, 3))
      else $error("sink mode wrong");
endmodule : fpg_gpio_properties
bind fpg_gpio fpg_gpio_properties chk_i (.*);

/* File: tb/fpg_gpio_tb.sv */
/* self-checking bench for fpg_gpio: registers, pins, open drain,
   peripheral takeover, reset. assumes fpg_pkg and the pad model. */
`timescale 1ns/1ns
module fpg_gpio_tb
   import fpg_pkg::*;
;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } fpg_row_t;
   logic                 clk_sys_in = 1'b0, rst_n_in = 1'b0;
   logic                 sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, iic_en_in = 1'b0;
   logic [7:0]           sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, rdv;
   logic [7:0]           sfr_rdata_out, common_drive_mode_out;
   logic [FPG_PIN_W-1:0] pin_in, pin_out, pin_oe_out, pin_pullup_out;
   logic [FPG_PIN_W-1:0] periph_sel_in = '0, periph_out_in = '0;
   logic [FPG_PIN_W-1:0] periph_oe_in = '0;
   int                   err_count = 0, checks = 0, cycles = 0;
   fpg_row_t rows [15] = '{
      '{8'hDD, 8'hFF, 8'h03}, '{8'hDE, 8'hA5, 8'hA5},
      '{8'hDF, 8'h5A, 8'h5A}, '{8'hE2, 8'h3C, 8'h3C},
      '{8'hEE, 8'hC3, 8'hC3}, '{8'hEF, 8'hFF, 8'h03},
      '{8'hEA, 8'hFE, 8'h02}, '{8'hEB, 8'h00, 8'h00},
      '{8'hEC, 8'h0F, 8'h0F}, '{8'hED, 8'hF0, 8'hF0},
      '{8'hF8, 8'h00, 8'h02}, '{8'h80, 8'h5A, 8'h5A},
      '{8'h90, 8'h33, 8'h3A}, '{8'h98, 8'h55, 8'hA5},
      '{8'h00, 8'h77, 8'h00}};
   fpg_gpio fpg_gpio_i (.*);
   fpg_pad_model fpg_pad_model_i (.clk_sys_in(clk_sys_in),
      .drv_in(pin_out), .oe_in(pin_oe_out), .pullup_in(pin_pullup_out),
      .ext_en_in('1), .ext_in(26'h2AAAAAA), .pad_out(pin_in));
   always #4 clk_sys_in = ~clk_sys_in;
   // hang guard
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic check(input logic [25:0] got, input logic [25:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(negedge clk_sys_in);
      sfr_wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(negedge clk_sys_in);
      sfr_rd_in = 1'b0;
      rdv = sfr_rdata_out;
   endtask : rd
   task automatic do_reset;
      rst_n_in = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      check(pin_oe_out | pin_pullup_out, '0);
      check(26'({sfr_rdata_out, common_drive_mode_out}), '0);
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
   endtask : do_reset
   task automatic end_of_test;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         @(negedge clk_sys_in);
         check(26'(rdv), 26'(rows[i].e));
      end
      check(pin_oe_out, 26'h03FC3FD);
      check(pin_out & pin_oe_out, 26'h014C168);
      check(pin_pullup_out, 26'h0F16A97);
      check(26'(common_drive_mode_out), 26'hC3);
      wr(8'hF8, 8'h01);
      @(negedge clk_sys_in);
      check(26'(pin_oe_out[1:0]), '0);
      wr(8'hEF, 8'h00);
      @(negedge clk_sys_in);
      check(26'({pin_oe_out[1:0], pin_out[0]}), 26'h3);
      iic_en_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      check(26'(pin_oe_out[1:0]), '0);
      periph_sel_in = 26'h00003FC;
      periph_out_in = 26'h000030C;
      periph_oe_in = 26'h00003C0;
      repeat (2) @(negedge clk_sys_in);
      check(26'({pin_oe_out[9:2], pin_out[9:2]}), 26'hF0C3);
      rd(8'h80);
      check(26'(rdv), 26'h5A);
      do_reset();
      end_of_test();
   end
endmodule : fpg_gpio_tb

/* File: tb/fpg_pad_model.sv */
/* pad model: resolves each pad from block drive, an outside
   driver and the pull-up. assumes the bench clock. */
`timescale 1ns/1ns
module fpg_pad_model
   import fpg_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic [FPG_PIN_W-1:0] drv_in,
   input  wire logic [FPG_PIN_W-1:0] oe_in,
   input  wire logic [FPG_PIN_W-1:0] pullup_in,
   input  wire logic [FPG_PIN_W-1:0] ext_en_in,
   input  wire logic [FPG_PIN_W-1:0] ext_in,
   output logic      [FPG_PIN_W-1:0] pad_out
);
   logic [FPG_PIN_W-1:0] wander = '0;
   // an undriven pad without pull-up never holds a level
   always @(posedge clk_sys_in) wander <= ~wander;
   // block drive wins, then the outside driver, then the pull-up
   assign pad_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
      | (~oe_in & ~ext_en_in & (pullup_in | wander));
endmodule : fpg_pad_model
